// ===== src/dcat_consts.svh
// offsets, field positions, trigger codes and reset values of the channel block
`ifndef DCAT_CONSTS_SVH
`define DCAT_CONSTS_SVH

// ***********************
// register map
// ***********************
`define DCAT_OFS_CTRL 4'h0
`define DCAT_OFS_STATUS 4'h1
`define DCAT_OFS_STEPCTRL 4'h2
`define DCAT_OFS_TRIGSEL 4'h3
`define DCAT_RST_STEPCTRL 8'h00
`define DCAT_RST_TRIGSEL 8'h00

// ***********************
// field positions
// ***********************
`define DCAT_CTRL_SWREQ 4
`define DCAT_STAT_BUSY 7
`define DCAT_STAT_PEND 6
`define DCAT_STAT_ACK 5

// ***********************
// trigger codes
// ***********************
`define DCAT_TRIG_OFF 8'h00
`define DCAT_TRIG_EVT 8'h01
`define DCAT_TRIG_EVT_CNT 8'h03
`define DCAT_TRIG_CIPHER 8'h04
`define DCAT_TRIG_ADC0 8'h10
`define DCAT_TRIG_DAC0 8'h15
`define DCAT_TRIG_ADC1 8'h20
`define DCAT_TRIG_DAC1 8'h25
`define DCAT_ADC_OFS_CNT 8'h05
`define DCAT_DAC_OFS_CNT 8'h02
`define DCAT_TC0_OFS 4'h0
`define DCAT_TC1_OFS 4'h6
`define DCAT_TC1_CNT 4'h4
`define DCAT_SPI_OFS 4'ha
`define DCAT_SER0_OFS 4'hb
`define DCAT_SER1_OFS 4'he
`define DCAT_SER_GAP 4'hd

// ***********************
// request vector layout
// ***********************
`define DCAT_REQ_N 78
`define DCAT_IDX_EVT 7'h00
`define DCAT_IDX_CIPHER 7'h03
`define DCAT_IDX_ADC0 7'h04
`define DCAT_IDX_ADC0_ALL 7'h08
`define DCAT_IDX_DAC0 7'h09
`define DCAT_IDX_ADC1 7'h0b
`define DCAT_IDX_ADC1_ALL 7'h0f
`define DCAT_IDX_DAC1 7'h10
`define DCAT_IDX_PORT0 7'h12
`define DCAT_IDX_PORT_SPAN 7'h0f
`define DCAT_ADDR_W 24

`endif

// ===== src/dcat_pkg.sv
// types of the channel addressing and trigger block
package dcat_pkg;

	typedef enum logic [1:0] {
		STEP_FIXED = 2'h0,
		STEP_UP = 2'h1,
		STEP_DOWN = 2'h2,
		STEP_RSVD = 2'h3
	} dcat_step_t;

	typedef enum logic [1:0] {
		RESTORE_NONE = 2'h0,
		RESTORE_BLOCK = 2'h1,
		RESTORE_BURST = 2'h2,
		RESTORE_TXN = 2'h3
	} dcat_restore_t;

	typedef struct packed {
		logic [1:0] srcRestoreRsvd;
		dcat_step_t srcStep;
		dcat_restore_t dstRestore;
		dcat_step_t dstStep;
	} dcat_stepcfg_t;

	typedef struct packed {
		logic txnStart;
		logic txnDone;
		logic txnError;
		logic chanOff;
		logic byteMoved;
		logic blockEnd;
		logic burstEnd;
	} dcat_engine_ev_t;

	typedef enum logic [2:0] {
		PEND_IDLE = 3'b001,
		PEND_ARMED = 3'b010,
		PEND_ACK = 3'b100
	} dcat_pend_t;

endpackage

// ===== src/dcat_trig_decode.sv
// trigger code to request-vector index decoder
`timescale 1ns/1ns
`include "dcat_consts.svh"

module dcat_trig_decode (
	input wire logic [7:0] code,
	output logic [6:0] index,
	output logic hit
);

	// ***********************
	// decode
	// ***********************
	function automatic logic [7:0] decode(input logic [7:0] c);
		logic [6:0] port;
		logic [3:0] lo;
		logic [7:0] r;
		// bases 0x40, 0x60, 0x80, 0xa0 map to ports 0..3 by bits 7 and 5
		port = {5'h0, c[7], c[5]};
		lo = c[3:0];
		r = 8'h00;
		if (c == `DCAT_TRIG_OFF) begin
			r = 8'h00;
		end else if (c >= `DCAT_TRIG_EVT && c < `DCAT_TRIG_EVT + `DCAT_TRIG_EVT_CNT) begin
			r = {1'b1, 7'(c - `DCAT_TRIG_EVT) + `DCAT_IDX_EVT};
		end else if (c == `DCAT_TRIG_CIPHER) begin
			r = {1'b1, `DCAT_IDX_CIPHER};
		end else if (c >= `DCAT_TRIG_ADC0 && c < `DCAT_TRIG_ADC0 + `DCAT_ADC_OFS_CNT) begin
			r = {1'b1, 7'(c - `DCAT_TRIG_ADC0) + `DCAT_IDX_ADC0};
		end else if (c >= `DCAT_TRIG_ADC1 && c < `DCAT_TRIG_ADC1 + `DCAT_ADC_OFS_CNT) begin
			r = {1'b1, 7'(c - `DCAT_TRIG_ADC1) + `DCAT_IDX_ADC1};
		end else if (c >= `DCAT_TRIG_DAC0 && c < `DCAT_TRIG_DAC0 + `DCAT_DAC_OFS_CNT) begin
			r = {1'b1, 7'(c - `DCAT_TRIG_DAC0) + `DCAT_IDX_DAC0};
		end else if (c >= `DCAT_TRIG_DAC1 && c < `DCAT_TRIG_DAC1 + `DCAT_DAC_OFS_CNT) begin
			r = {1'b1, 7'(c - `DCAT_TRIG_DAC1) + `DCAT_IDX_DAC1};
		end else if (c[7:4] == 4'h4 || c[7:4] == 4'h6 || c[7:4] == 4'h8 || c[7:4] == 4'ha) begin
			if (lo >= `DCAT_TC1_OFS + `DCAT_TC1_CNT && lo < `DCAT_SPI_OFS) begin
				r = 8'h00;
			end else if (lo == `DCAT_SER_GAP) begin
				r = 8'h00;
			end else if (lo > `DCAT_SER_GAP) begin
				r = {1'b1, 7'(lo - 4'h1) + `DCAT_IDX_PORT0 + port * `DCAT_IDX_PORT_SPAN};
			end else begin
				r = {1'b1, 7'(lo - `DCAT_TC0_OFS) + `DCAT_IDX_PORT0 + port * `DCAT_IDX_PORT_SPAN};
			end
		end
		return r;
	endfunction

	always_comb begin
		{hit, index} = decode(code);
	end

endmodule // dcat_trig_decode

// ===== src/dcat_channel.sv
// dma channel address stepping and trigger selection
// Behaviour
// - source step field: 00 fixed, 01 up, 10 down, 11 reserved
// - step and restore fields hold old value while channel busy
// - destination restore: never, per block, per burst, per transaction
// - destination step field: 00 fixed, 01 up, 10 down, 11 reserved
// - trigger code picks hardware request; zero means software only
// - trigger code is peripheral base plus per-request offset
// - codes of absent peripherals select no request
// - pending request dropped if flag cleared or interrupt enabled
// - servicing a request may clear the peripheral flag
// - event routing base 0x01, offsets 0 to 2
// - cipher request is code 0x04
// - converter bases 0x10, 0x15, 0x20, 0x25
// - sampler offsets 0 to 3 single, 4 all channels together
// - output converters offer offsets 0 and 1 only
// - timer bases 0x40/0x46, 0x60/0x66, 0x80/0x86, 0xa0/0xa6
// - timer offsets: wrap, error, match a, b, c, d
// - match c and d exist only on first timer of port
// - serial peripheral codes 0x4a, 0x6a, 0x8a, 0xaa
// - async serial bases 0x4b/0x4e and their later port copies
// - async serial offsets: receive done 0, transmit empty 1
// - busy from transaction start until off, done or error
`timescale 1ns/1ns
`include "dcat_consts.svh"

module dcat_channel #(
	parameter logic [`DCAT_REQ_N-1:0] PRESENT = {`DCAT_REQ_N{1'b1}}
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata,
	input wire dcat_pkg::dcat_engine_ev_t engineEv,
	input wire logic serviceTake,
	input wire logic [`DCAT_REQ_N-1:0] hwReq,
	input wire logic [`DCAT_REQ_N-1:0] irqEnabled,
	input wire logic [`DCAT_ADDR_W-1:0] srcInit,
	input wire logic [`DCAT_ADDR_W-1:0] dstInit,
	output logic [`DCAT_ADDR_W-1:0] srcAddr,
	output logic [`DCAT_ADDR_W-1:0] dstAddr,
	output logic chanTrigger,
	output logic [`DCAT_REQ_N-1:0] reqAck
);

	// ***********************
	// helpers
	// ***********************
	function automatic logic [`DCAT_ADDR_W-1:0] stepAddr(
		input logic [`DCAT_ADDR_W-1:0] a,
		input dcat_pkg::dcat_step_t m
	);
		logic [`DCAT_ADDR_W-1:0] r;
		r = a;
		case (m)
			dcat_pkg::STEP_UP: begin
				r = a + `DCAT_ADDR_W'(1);
			end
			dcat_pkg::STEP_DOWN: begin
				r = a - `DCAT_ADDR_W'(1);
			end
			// reserved code behaves as fixed, no stray movement
			default: begin
				r = a;
			end
		endcase
		return r;
	endfunction

	function automatic logic isAccess(input logic [3:0] a, input logic [3:0] ofs, input logic s);
		return s && (a == ofs);
	endfunction

	// ***********************
	// trigger decode
	// ***********************
	logic [6:0] selIndex;
	logic selHit;
	logic [`DCAT_REQ_N-1:0] reqVec;
	logic selValid;
	logic selLevel;
	logic selIrqOn;
	logic [7:0] trigSel_q;
	logic [7:0] trigSel_d;
	dcat_pkg::dcat_pend_t pend_q;
	dcat_pkg::dcat_pend_t pend_d;

	dcat_trig_decode decodeInst (
		.code(trigSel_q),
		.index(selIndex),
		.hit(selHit)
	);

	always_comb begin
		reqVec = hwReq;
		reqVec[`DCAT_IDX_ADC0_ALL] = &hwReq[`DCAT_IDX_ADC0 +: 4];
		reqVec[`DCAT_IDX_ADC1_ALL] = &hwReq[`DCAT_IDX_ADC1 +: 4];
		selValid = selHit && (selIndex < 7'(`DCAT_REQ_N)) && PRESENT[selIndex];
		selLevel = selValid && reqVec[selIndex];
		selIrqOn = selValid && irqEnabled[selIndex];
	end

	// ***********************
	// registers
	// ***********************
	dcat_pkg::dcat_stepcfg_t stepCfg_q;
	dcat_pkg::dcat_stepcfg_t stepCfg_d;
	logic busy_q;
	logic busy_d;
	logic swReq_q;
	logic swReq_d;
	logic ackSeen_q;
	logic ackSeen_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic wrCtrl;
	logic wrStat;
	logic wrStep;
	logic wrTrig;

	always_comb begin
		wrCtrl = isAccess(regAddr, `DCAT_OFS_CTRL, regWrite);
		wrStat = isAccess(regAddr, `DCAT_OFS_STATUS, regWrite);
		wrStep = isAccess(regAddr, `DCAT_OFS_STEPCTRL, regWrite);
		wrTrig = isAccess(regAddr, `DCAT_OFS_TRIGSEL, regWrite);
		stepCfg_d = stepCfg_q;
		if (wrStep && !busy_q) begin
			stepCfg_d = dcat_pkg::dcat_stepcfg_t'({2'h0, regWdata[5:0]});
		end
		trigSel_d = wrTrig ? regWdata : trigSel_q;
		busy_d = busy_q;
		if (engineEv.txnDone || engineEv.txnError || engineEv.chanOff) begin
			busy_d = 1'b0;
		end else if (engineEv.txnStart) begin
			busy_d = 1'b1;
		end
		// software request lasts one cycle on the trigger output
		swReq_d = wrCtrl && regWdata[`DCAT_CTRL_SWREQ];
		// sticky ack note, set wins over clear
		ackSeen_d = ackSeen_q;
		if (wrStat && regWdata[`DCAT_STAT_ACK]) begin
			ackSeen_d = 1'b0;
		end
		if (pend_q == dcat_pkg::PEND_ACK) begin
			ackSeen_d = 1'b1;
		end
		rdata_d = 8'h00;
		if (regRead) begin
			case (regAddr)
				`DCAT_OFS_CTRL: begin
					rdata_d = 8'h00;
				end
				`DCAT_OFS_STATUS: begin
					rdata_d[`DCAT_STAT_BUSY] = busy_q;
					rdata_d[`DCAT_STAT_PEND] = (pend_q == dcat_pkg::PEND_ARMED);
					rdata_d[`DCAT_STAT_ACK] = ackSeen_q;
				end
				`DCAT_OFS_STEPCTRL: begin
					rdata_d = stepCfg_q;
				end
				`DCAT_OFS_TRIGSEL: begin
					rdata_d = trigSel_q;
				end
				default: begin
					rdata_d = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stepCfg_q <= dcat_pkg::dcat_stepcfg_t'(`DCAT_RST_STEPCTRL);
			trigSel_q <= `DCAT_RST_TRIGSEL;
			busy_q <= 1'b0;
			swReq_q <= 1'b0;
			ackSeen_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			stepCfg_q <= stepCfg_d;
			trigSel_q <= trigSel_d;
			busy_q <= busy_d;
			swReq_q <= swReq_d;
			ackSeen_q <= ackSeen_d;
			rdata_q <= rdata_d;
		end
	end

	// ***********************
	// hardware request tracking
	// ***********************
	logic [6:0] ackIdx_q;
	logic [6:0] ackIdx_d;
	logic trig_q;
	logic trig_d;
	logic [`DCAT_REQ_N-1:0] ack_q;
	logic [`DCAT_REQ_N-1:0] ack_d;

	always_comb begin
		pend_d = pend_q;
		ackIdx_d = ackIdx_q;
		ack_d = '0;
		case (pend_q)
			dcat_pkg::PEND_IDLE: begin
				if (selLevel && !selIrqOn) begin
					pend_d = dcat_pkg::PEND_ARMED;
					ackIdx_d = selIndex;
				end
			end
			dcat_pkg::PEND_ARMED: begin
				// flag cleared or irq enabled drops
				if (!selLevel || selIrqOn || selIndex != ackIdx_q) begin
					pend_d = dcat_pkg::PEND_IDLE;
				end else if (serviceTake) begin
					pend_d = dcat_pkg::PEND_ACK;
				end
			end
			dcat_pkg::PEND_ACK: begin
				ack_d[ackIdx_q] = 1'b1;
				pend_d = dcat_pkg::PEND_IDLE;
			end
			default: begin
				pend_d = dcat_pkg::PEND_IDLE;
			end
		endcase
		trig_d = swReq_d || (pend_d == dcat_pkg::PEND_ARMED);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pend_q <= dcat_pkg::PEND_IDLE;
			ackIdx_q <= 7'h00;
			trig_q <= 1'b0;
			ack_q <= '0;
		end else begin
			pend_q <= pend_d;
			ackIdx_q <= ackIdx_d;
			trig_q <= trig_d;
			ack_q <= ack_d;
		end
	end

	// ***********************
	// address stepping
	// ***********************
	logic [`DCAT_ADDR_W-1:0] src_q;
	logic [`DCAT_ADDR_W-1:0] src_d;
	logic [`DCAT_ADDR_W-1:0] dst_q;
	logic [`DCAT_ADDR_W-1:0] dst_d;
	logic dstRestore;

	always_comb begin
		case (stepCfg_q.dstRestore)
			dcat_pkg::RESTORE_BLOCK: begin
				dstRestore = engineEv.blockEnd;
			end
			dcat_pkg::RESTORE_BURST: begin
				dstRestore = engineEv.burstEnd;
			end
			dcat_pkg::RESTORE_TXN: begin
				dstRestore = engineEv.txnDone;
			end
			default: begin
				dstRestore = 1'b0;
			end
		endcase
		src_d = src_q;
		dst_d = dst_q;
		if (engineEv.txnStart && !busy_q) begin
			src_d = srcInit;
			dst_d = dstInit;
		end else if (engineEv.byteMoved) begin
			src_d = stepAddr(src_q, stepCfg_q.srcStep);
			dst_d = stepAddr(dst_q, stepCfg_q.dstStep);
		end
		// restore wins over a step in the same cycle
		if (dstRestore) begin
			dst_d = dstInit;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			src_q <= '0;
			dst_q <= '0;
		end else begin
			src_q <= src_d;
			dst_q <= dst_d;
		end
	end

	// ***********************
	// outputs
	// ***********************
	// withdrawal is the peripheral's job
	assign regRdata = rdata_q;
	assign srcAddr = src_q;
	assign dstAddr = dst_q;
	assign chanTrigger = trig_q;
	assign reqAck = ack_q;

endmodule // dcat_channel

// ===== verification/dcat_periph_model.sv
// peripheral request levels seen by the channel
`timescale 1ns/1ns
`include "dcat_consts.svh"
module dcat_periph_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [`DCAT_REQ_N-1:0] raise,
	input wire logic [`DCAT_REQ_N-1:0] drop,
	input wire logic [`DCAT_REQ_N-1:0] reqAck,
	output logic [`DCAT_REQ_N-1:0] hwReq
);
	// ****
	// request flags
	// ****
	logic [`DCAT_REQ_N-1:0] req_q, req_d;
	always_comb begin
		req_d = (req_q | raise) & ~(drop | reqAck);
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			req_q <= '0;
		end else begin
			req_q <= req_d;
		end
	end
	assign hwReq = req_q;
endmodule // dcat_periph_model

// ===== verification/dcat_channel_props.sv
// port assertions of the channel block
`timescale 1ns/1ns
`include "dcat_consts.svh"
module dcat_channel_props (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdata,
	input wire dcat_pkg::dcat_engine_ev_t engineEv,
	input wire logic serviceTake,
	input wire logic [`DCAT_ADDR_W-1:0] srcInit,
	input wire logic [`DCAT_ADDR_W-1:0] dstInit,
	input wire logic [`DCAT_ADDR_W-1:0] srcAddr,
	input wire logic [`DCAT_ADDR_W-1:0] dstAddr,
	input wire logic chanTrigger,
	input wire logic [`DCAT_REQ_N-1:0] reqAck
);
	// ****
	// shadow of busy and step settings
	// ****
	logic busy_q, busy_d;
	logic [5:0] cfg_q, cfg_d;
	logic [1:0] srcMode, dstMode;
	assign srcMode = cfg_q[5:4];
	assign dstMode = cfg_q[1:0];
	always_comb begin
		busy_d = busy_q;
		cfg_d = cfg_q;
		if (regWrite && regAddr == 4'h2 && !busy_q) begin
			cfg_d = regWdata[5:0];
		end
		if (engineEv.txnStart) begin
			busy_d = 1'b1;
		end
		if (engineEv.txnDone || engineEv.txnError || engineEv.chanOff) begin
			busy_d = 1'b0;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy_q <= 1'b0;
			cfg_q <= 6'h00;
		end else begin
			busy_q <= busy_d;
			cfg_q <= cfg_d;
		end
	end
	function automatic logic [23:0] stepOf(input logic [23:0] a, input logic [1:0] m);
		return (m == 2'h1) ? a + 24'h1 : (m == 2'h2) ? a - 24'h1 : a;
	endfunction
	// ****
	// properties
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_move;
		engineEv == 7'h04;
	endsequence
	sequence s_take;
		chanTrigger && serviceTake;
	endsequence
	property p_srcStep;
		s_move |=> srcAddr == stepOf($past(srcAddr), $past(srcMode));
	endproperty
	a_srcStep: assert property (p_srcStep) else $error("source step wrong");
	property p_dstStep;
		s_move |=> dstAddr == stepOf($past(dstAddr), $past(dstMode));
	endproperty
	a_dstStep: assert property (p_dstStep) else $error("destination step wrong");
	property p_wrap;
		engineEv == 7'h04 && srcAddr == 24'hffffff && srcMode == 2'h1 |=> srcAddr == 24'h000000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("source did not wrap");
	property p_srcHold;
		!engineEv.txnStart && !engineEv.byteMoved |=> $stable(srcAddr);
	endproperty
	a_srcHold: assert property (p_srcHold) else $error("source moved idle");
	property p_load;
		engineEv == 7'h40 && !busy_q |=> srcAddr == $past(srcInit) && dstAddr == $past(dstInit);
	endproperty
	a_load: assert property (p_load) else $error("start did not load");
	property p_restore;
		(engineEv == 7'h02 && cfg_q[3:2] == 2'h1) || (engineEv == 7'h01 && cfg_q[3:2] == 2'h2)
			|| (engineEv == 7'h20 && cfg_q[3:2] == 2'h3) |=> dstAddr == $past(dstInit);
	endproperty
	a_restore: assert property (p_restore) else $error("restore missed");
	property p_cfgRead;
		regRead && regAddr == 4'h2 |=> regRdata == {2'b00, cfg_q};
	endproperty
	a_cfgRead: assert property (p_cfgRead) else $error("step setting changed");
	property p_swTrig;
		regWrite && regAddr == 4'h0 && regWdata[4] |=> chanTrigger;
	endproperty
	a_swTrig: assert property (p_swTrig) else $error("software trigger lost");
	property p_ackOne;
		reqAck != '0 |-> $onehot(reqAck) ##1 reqAck == '0;
	endproperty
	a_ackOne: assert property (p_ackOne) else $error("flag clear not one pulse");
	property p_svc;
		s_take |=> !chanTrigger ##1 $onehot(reqAck);
	endproperty
	a_svc: assert property (p_svc) else $error("service sequence wrong");
endmodule // dcat_channel_props
bind dcat_channel dcat_channel_props u_props (.clk(clk), .rstn(rstn), .regAddr(regAddr),
	.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
	.engineEv(engineEv), .serviceTake(serviceTake), .srcInit(srcInit), .dstInit(dstInit),
	.srcAddr(srcAddr), .dstAddr(dstAddr), .chanTrigger(chanTrigger), .reqAck(reqAck));

// ===== verification/dcat_channel_test.sv
// self-checking bench of the channel block
`timescale 1ns/1ns
`include "dcat_consts.svh"
module dcat_channel_test;
	localparam int N = `DCAT_REQ_N;
	// last serial request absent
	localparam logic [N-1:0] PRES = {1'b0, {(N-1){1'b1}}};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWdata = 8'h00, regRdata;
	logic regWrite = 1'b0, regRead = 1'b0, serviceTake = 1'b0, chanTrigger;
	dcat_pkg::dcat_engine_ev_t engineEv = '0;
	logic [N-1:0] hwReq, reqAck, raise = '0, drop = '0, irqEnabled = '0;
	logic [23:0] srcInit = 24'h0, dstInit = 24'h0, srcAddr, dstAddr, eSrc, eDst;
	logic [7:0] rdQ[$];
	logic [N-1:0] ackQ[$];
	logic [47:0] adrQ[$];
	logic rdPend = 1'b0, evPend = 1'b0, busy = 1'b0;
	logic [5:0] cfg = 6'h00;
	int numErrors = 0, checks = 0, cycles = 0;
	always #10 clk = ~clk;
	dcat_channel #(.PRESENT(PRES)) u_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.engineEv(engineEv), .serviceTake(serviceTake), .hwReq(hwReq), .irqEnabled(irqEnabled),
		.srcInit(srcInit), .dstInit(dstInit), .srcAddr(srcAddr), .dstAddr(dstAddr),
		.chanTrigger(chanTrigger), .reqAck(reqAck));
	dcat_periph_model u_periph (.clk(clk), .rstn(rstn), .raise(raise), .drop(drop),
		.reqAck(reqAck), .hwReq(hwReq));
	// ****
	// compare and bus tasks
	// ****
	task automatic note(input logic [79:0] g, input logic [79:0] e);
		checks++;
		if (g !== e) begin
			numErrors++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmpRd(input logic [7:0] g, input logic [7:0] e);
		note({72'h0, g}, {72'h0, e});
	endtask
	task automatic cmpAdr(input logic [47:0] g, input logic [47:0] e);
		note({32'h0, g}, {32'h0, e});
	endtask
	task automatic cmpAck(input logic [N-1:0] g, input logic [N-1:0] e);
		note(80'(g), 80'(e));
	endtask
	task automatic cmpTrg(input logic g, input logic e);
		note({79'h0, g}, {79'h0, e});
	endtask
	task automatic results;
		$display("errors %0d checks %0d", numErrors, checks);
		if (numErrors == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
		if (a == 4'h2 && !busy) cfg = d[5:0];
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		rdQ.push_back(e);
		@(posedge clk);
		regRead <= 1'b0;
	endtask
	function automatic logic [23:0] stp(input logic [23:0] a, input logic [1:0] m);
		return (m == 2'h1) ? a + 24'h1 : (m == 2'h2) ? a - 24'h1 : a;
	endfunction
	task automatic ev(input logic [6:0] e);
		@(posedge clk);
		engineEv <= e;
		if (e[6] && !busy) {eSrc, eDst} = {srcInit, dstInit};
		busy = (busy | e[6]) & ~(e[5] | e[4] | e[3]);
		if (e[2]) {eSrc, eDst} = {stp(eSrc, cfg[5:4]), stp(eDst, cfg[1:0])};
		if ((e[1] && cfg[3:2] == 2'h1) || (e[0] && cfg[3:2] == 2'h2)) eDst = dstInit;
		if (e[5] && cfg[3:2] == 2'h3) eDst = dstInit;
		adrQ.push_back({eSrc, eDst});
		@(posedge clk);
		engineEv <= '0;
	endtask
	task automatic trg(input logic [7:0] c, input logic [N-1:0] m, input logic [N-1:0] a);
		int n;
		wr(4'h3, c);
		raise <= m;
		@(posedge clk);
		raise <= '0;
		for (n = 0; n < 6 && chanTrigger !== 1'b1; n++) @(posedge clk);
		cmpTrg(chanTrigger, a != '0);
		if (a != '0) begin
			serviceTake <= 1'b1;
			ackQ.push_back(a);
			@(posedge clk);
			serviceTake <= 1'b0;
		end
		repeat (4) @(posedge clk);
		drop <= '1;
		@(posedge clk);
		drop <= '0;
	endtask
	// ****
	// result watcher
	// ****
	always @(posedge clk) begin
		cycles++;
		if (rdPend) cmpRd(regRdata, rdQ.pop_front());
		if (evPend) cmpAdr({srcAddr, dstAddr}, adrQ.pop_front());
		if (reqAck !== '0) cmpAck(reqAck, ackQ.pop_front());
		rdPend <= regRead;
		evPend <= (engineEv != '0);
		if (cycles == 20000) begin
			numErrors++;
			results();
		end
	end
	// ****
	// tests
	// ****
	initial begin
		int i, k;
		logic [N-1:0] a;
		logic [7:0] d;
		logic [7:0] lo[18] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
			8'h15, 8'h16, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26};
		logic [7:0] bad[7] = '{8'h00, 8'h05, 8'h17, 8'h27, 8'h4d, 8'hb0, 8'hff};
		logic [6:0] seqv[8] = '{7'h04, 7'h04, 7'h01, 7'h04, 7'h02, 7'h04, 7'h04, 7'h01};
		void'($urandom(32'hcee4));
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		d = 8'($urandom);
		rd(4'h3, 8'h00);
		rd(4'h2, 8'h00);
		wr(4'h3, d);
		rd(4'h3, d);
		wr(4'h7, d);
		rd(4'h7, 8'h00);
		$display("register test done");
		for (k = 0; k < 18; k++) begin
			a = N'(1) << k;
			trg(lo[k], (k == 8) ? N'('hf0) : (k == 15) ? N'('h7800) : a, a);
		end
		for (k = 18; k < N; k++) begin
			a = N'(1) << k;
			i = (k - 18) % 15;
			d = 8'h40 + 8'((k - 18) / 15) * 8'h20 + 8'(i) + ((i >= 13) ? 8'h1 : 8'h0);
			trg(d, (k == N - 1) ? '1 : a, (k == N - 1) ? '0 : a);
		end
		foreach (bad[j]) trg(bad[j], '1, '0);
		irqEnabled[3] <= 1'b1;
		trg(8'h04, N'('h8), '0);
		irqEnabled <= '0;
		wr(4'h0, 8'h10);
		#1 cmpTrg(chanTrigger, 1'b1);
		// sticky service note set by earlier acks, write one clears it
		rd(4'h1, 8'h20);
		wr(4'h1, 8'h20);
		rd(4'h1, 8'h00);
		$display("trigger test done");
		for (i = 0; i < 64; i++) begin
			srcInit <= (i % 3 == 0) ? 24'hffffff : 24'($urandom);
			dstInit <= (i % 3 == 0) ? 24'h000000 : 24'($urandom);
			wr(4'h2, 8'(i));
			ev(7'h40);
			rd(4'h1, 8'h80);
			wr(4'h2, ~8'(i));
			foreach (seqv[j]) ev(seqv[j]);
			rd(4'h2, {2'b00, cfg});
			ev(i[0] ? 7'h20 : i[1] ? 7'h10 : 7'h08);
			ev(7'h04);
		end
		repeat (4) @(posedge clk);
		$display("address test done");
		results();
	end
endmodule // dcat_channel_test
